//--- hw/wideband_decimation_filter.sv
// decimating wideband filter path with sync restart, suppression and register port
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module wideband_decimation_filter #(
    parameter int unsigned CONV_CLK_DIV = 1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [wideband_filter_pkg::QUANT_W-1:0] modulator_word,
    input wire logic modulator_saturated,
    input wire logic sync_n,
    input wire logic [wideband_filter_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [wideband_filter_pkg::WORD_W-1:0] data_word,
    output logic modulator_saturation_flag,
    output logic conversion_ready_strobe_n,
    output logic irq
);
    import wideband_filter_pkg::*;

    typedef enum logic [2:0] {
        PUB_IDLE = 3'b001,
        PUB_OVERHEAD = 3'b010,
        PUB_BUFWAIT = 3'b100
    } pub_state_t;

    typedef struct packed {
        logic [QUANT_W-1:0] word_s1;
        logic [QUANT_W-1:0] word_s2;
        logic sat_s1;
        logic sat_s2;
        logic sync_s1;
        logic sync_s2;
        logic sync_prev;
        logic [7:0] div_cnt;
        logic [2:0] slow_cnt;
        logic mod_phase;
        logic signed [STAGE1_W-1:0] acc1;
        logic [11:0] samp_cnt;
        logic [HIST_TAPS-1:0][STAGE1_W-1:0] hist;
        logic [6:0] hist_ptr;
        logic signed [SUM2_W-1:0] sum2;
        logic [6:0] sup_cnt;
        logic sat_sticky;
        pub_state_t pub;
        logic [3:0] ovh_cnt;
        logic [3:0] buf_cnt;
        result_t pend;
        result_t out;
        logic settled;
        logic conversion_ready_strobe_n_n;
        ctrl_t ctrl;
        logic [EV_W-1:0] int_en;
        logic [EV_W-1:0] status;
        logic irq;
        logic [31:0] rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic soft_sync;
    logic restart;
    logic div_last;
    logic slow_last;
    logic conv_tick;
    logic mod_tick;
    logic ratio_last;
    logic done;
    logic suppress;
    logic sat_captured;
    logic publish;
    logic signed [STAGE1_W-1:0] sample;
    logic signed [STAGE1_W-1:0] stage1;
    logic signed [SUM2_W-1:0] new_sum;
    logic signed [PROD_W-1:0] prod_wb;
    logic signed [PROD_W-1:0] prod_ll;
    logic [4:0] out_shift;
    logic [WORD_W-1:0] conv_word;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] ev_clear;
    logic [31:0] read_mux;

    always_comb begin
        st_next = st_reg;

        // pins come from outside the clock domain: two flops before use
        st_next.word_s1 = modulator_word;
        st_next.word_s2 = st_reg.word_s1;
        st_next.sat_s1 = modulator_saturated;
        st_next.sat_s2 = st_reg.sat_s1;
        st_next.sync_s1 = sync_n;
        st_next.sync_s2 = st_reg.sync_s1;
        st_next.sync_prev = st_reg.sync_s2;

        ev = '0;
        st_next.conversion_ready_strobe_n_n = 1'b1;
        publish = 1'b0;

        // sync pin falling edge or software sync bit
        soft_sync = reg_wr && (reg_addr == ADDR_CTRL) && reg_wdata[CTRL_SYNC_BIT];
        restart = (st_reg.sync_prev && !st_reg.sync_s2) || soft_sync;

        // converter clock tick, optionally slowed for low speed
        div_last = st_reg.div_cnt == 8'(CONV_CLK_DIV - 1);
        slow_last = (st_reg.ctrl.speed == SPEED_HIGH) ||
                    (st_reg.slow_cnt == 3'(LOW_SPEED_DIV - 1));
        conv_tick = div_last && slow_last;
        st_next.div_cnt = div_last ? 8'h00 : st_reg.div_cnt + 8'h01;
        if (div_last) begin
            st_next.slow_cnt = slow_last ? 3'h0 : st_reg.slow_cnt + 3'h1;
        end
        // every second converter tick is a modulator sample
        mod_tick = conv_tick && st_reg.mod_phase;
        if (conv_tick) begin
            st_next.mod_phase = ~st_reg.mod_phase;
        end

        // first stage: boxcar accumulate over decimation_ratio samples
        sample = STAGE1_W'($signed(st_reg.word_s2));
        stage1 = st_reg.acc1 + sample;
        // a ratio cut mid-conversion ends it at once instead of wrapping the count
        ratio_last = st_reg.samp_cnt >= decimation_last(st_reg.ctrl.ratio_code);
        done = mod_tick && ratio_last;
        if (mod_tick) begin
            if (ratio_last) begin
                st_next.acc1 = '0;
                st_next.samp_cnt = 12'h000;
            end else begin
                st_next.acc1 = stage1;
                st_next.samp_cnt = st_reg.samp_cnt + 12'h001;
            end
        end

        // second stage: symmetric running sum over the last 69 conversions
        new_sum = st_reg.sum2 + SUM2_W'(stage1) -
                  SUM2_W'($signed(st_reg.hist[st_reg.hist_ptr]));
        prod_wb = PROD_W'(new_sum) * PROD_W'(GAIN_RECIP);
        prod_ll = PROD_W'(stage1) <<< LL_GAIN_SHIFT;
        out_shift = 5'(OUT_SHIFT_BASE) + 5'(st_reg.ctrl.ratio_code);
        if (st_reg.ctrl.mode == MODE_WIDEBAND) begin
            conv_word = scale_word(prod_wb, out_shift);
        end else begin
            conv_word = scale_word(prod_ll, out_shift);
        end

        // saturation: sticky inside a conversion, handed over at its end
        sat_captured = st_reg.sat_sticky || st_reg.sat_s2;
        st_next.sat_sticky = done ? 1'b0 : sat_captured;

        // suppression only follows a reset or restart; a bare input step is passed on
        suppress = (st_reg.ctrl.mode == MODE_WIDEBAND) &&
                   (st_reg.sup_cnt < 7'(SETTLE_PERIODS - 1));

        if (done) begin
            if (st_reg.ctrl.mode == MODE_WIDEBAND) begin
                st_next.hist[st_reg.hist_ptr] = stage1;
                st_next.hist_ptr = (st_reg.hist_ptr == 7'(HIST_TAPS - 1)) ?
                                   7'h00 : st_reg.hist_ptr + 7'h01;
                st_next.sum2 = new_sum;
                if (suppress) begin
                    st_next.sup_cnt = st_reg.sup_cnt + 7'h01;
                end
            end
            if (!suppress) begin
                st_next.pend.word = conv_word;
                st_next.pend.sat = sat_captured;
                st_next.pub = PUB_OVERHEAD;
                st_next.ovh_cnt = 4'(OVERHEAD_CYCLES - 1);
            end
        end

        // publication delay: fixed overhead, then buffer delay in converter clocks
        case (st_reg.pub)
            PUB_IDLE: begin
            end
            PUB_OVERHEAD: begin
                if (st_reg.ovh_cnt != 4'h0) begin
                    st_next.ovh_cnt = st_reg.ovh_cnt - 4'h1;
                end else if (st_reg.ctrl.buf_en) begin
                    st_next.pub = PUB_BUFWAIT;
                    st_next.buf_cnt = 4'(BUFFER_EXTRA_CLKS);
                end else begin
                    publish = 1'b1;
                end
            end
            PUB_BUFWAIT: begin
                if (conv_tick) begin
                    if (st_reg.buf_cnt == 4'h1) begin
                        publish = 1'b1;
                    end else begin
                        st_next.buf_cnt = st_reg.buf_cnt - 4'h1;
                    end
                end
            end
            default: begin
                st_next.pub = PUB_IDLE;
            end
        endcase

        // a conversion landing in the same cycle keeps its own pending copy
        if (publish) begin
            st_next.out = st_reg.pend;
            st_next.conversion_ready_strobe_n_n = 1'b0;
            st_next.settled = 1'b1;
            ev[EV_READY] = 1'b1;
            ev[EV_SAT] = st_reg.pend.sat;
            if (!(done && !suppress)) begin
                st_next.pub = PUB_IDLE;
            end
        end

        // restart wins over everything in flight; the word being published is lost
        if (restart) begin
            st_next.div_cnt = 8'h00;
            st_next.slow_cnt = 3'h0;
            st_next.mod_phase = 1'b0;
            st_next.acc1 = '0;
            st_next.samp_cnt = 12'h000;
            st_next.hist = '0;
            st_next.hist_ptr = 7'h00;
            st_next.sum2 = '0;
            st_next.sup_cnt = 7'h00;
            st_next.sat_sticky = 1'b0;
            st_next.pub = PUB_IDLE;
            st_next.conversion_ready_strobe_n_n = 1'b1;
            // the published word only moves together with the strobe
            st_next.out = st_reg.out;
            st_next.settled = 1'b0;
            ev[EV_READY] = 1'b0;
            ev[EV_SAT] = 1'b0;
            ev[EV_RESTART] = 1'b1;
        end

        // register writes
        if (reg_wr && (reg_addr == ADDR_CTRL)) begin
            st_next.ctrl.ratio_code = reg_wdata[CTRL_RATIO_LSB +: 3];
            st_next.ctrl.mode = filter_mode_t'(reg_wdata[CTRL_MODE_BIT]);
            st_next.ctrl.speed = speed_mode_t'(reg_wdata[CTRL_SPEED_BIT]);
            st_next.ctrl.buf_en = reg_wdata[CTRL_BUF_BIT];
        end
        if (reg_wr && (reg_addr == ADDR_INT_EN)) begin
            st_next.int_en = reg_wdata[EV_W-1:0];
        end
        ev_clear = (reg_wr && (reg_addr == ADDR_INT_CLEAR)) ? reg_wdata[EV_W-1:0] : '0;
        // set wins over a clear in the same cycle
        st_next.status = (st_reg.status & ~ev_clear) | ev;
        st_next.irq = |(st_next.status & st_next.int_en);

        // reads: data valid only in the cycle after the strobe
        case (reg_addr)
            ADDR_CTRL: begin
                read_mux = '0;
                read_mux[CTRL_RATIO_LSB +: 3] = st_reg.ctrl.ratio_code;
                read_mux[CTRL_MODE_BIT] = st_reg.ctrl.mode;
                read_mux[CTRL_SPEED_BIT] = st_reg.ctrl.speed;
                read_mux[CTRL_BUF_BIT] = st_reg.ctrl.buf_en;
            end
            ADDR_STATUS: begin
                read_mux = 32'(st_reg.status);
            end
            ADDR_INT_EN: begin
                read_mux = 32'(st_reg.int_en);
            end
            ADDR_DATA: begin
                read_mux = '0;
                read_mux[WORD_W-1:0] = st_reg.out.word;
                read_mux[DATA_SAT_BIT] = st_reg.out.sat;
                read_mux[DATA_SETTLED_BIT] = st_reg.settled;
            end
            default: begin
                read_mux = '0;
            end
        endcase
        st_next.rdata = reg_rd ? read_mux : '0;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.sync_s1 <= 1'b1;
            st_reg.sync_s2 <= 1'b1;
            st_reg.sync_prev <= 1'b1;
            st_reg.pub <= PUB_IDLE;
            st_reg.conversion_ready_strobe_n_n <= 1'b1;
            st_reg.ctrl.ratio_code <= RATIO_CODE_RESET;
            st_reg.ctrl.mode <= MODE_WIDEBAND;
            st_reg.ctrl.speed <= SPEED_HIGH;
            st_reg.int_en <= INT_EN_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign data_word = st_reg.out.word;
    assign modulator_saturation_flag = st_reg.out.sat;
    assign conversion_ready_strobe_n = st_reg.conversion_ready_strobe_n_n;
    assign irq = st_reg.irq;

endmodule
`default_nettype wire

//--- hw/wideband_filter_pkg.sv
// constants, types and helpers for the decimating wideband filter path
//
// Notes on behaviour
// - one signed 5-bit modulator word is taken per modulator sample tick
// - the modulator sample tick is the converter clock tick halved
// - one output word per decimation_ratio modulator samples
// - wideband or low-latency filter mode is selected by a control bit
// - wideband decimation_ratio is 32 shifted left by a 3-bit code, up to 4096
// - speed mode: low speed divides the converter clock by eight
// - stop band from half the output rate; output-rate smoothing stops Nyquist aliasing
// - symmetric 69-tap output stage gives linear phase, 34-period group delay
// - a step aligned to a conversion is fully settled 68 conversions later
// - every sync event restarts the filter and clears all its history
// - after a wideband restart the first 67 conversions are not signalled
// - a fixed 0.4 us overhead delays every published word
// - sync-to-first-word latency is 68 conversion periods in wideband, one in low latency, plus the overhead
// - enabled input buffers add 8 converter clock periods of latency
// - a step without a sync is not suppressed; in wideband the next 69 words are partially settled
// - saturation is latched within a conversion, refreshed when the next completes
// - output is a 16-bit two's-complement word clamped to 7FFF and 8000
package wideband_filter_pkg;

    localparam int MCLK_PERIOD_NS = 100;
    localparam int QUANT_W = 5;
    localparam int WORD_W = 16;
    localparam int STAGE1_W = 18;
    localparam int SUM2_W = 25;
    localparam int PROD_W = 36;

    localparam int RATE_HALVING = 2;
    localparam int LOW_SPEED_DIV = 8;
    localparam int GROUP_DELAY_PERIODS = 34;
    localparam int HIST_TAPS = 2 * GROUP_DELAY_PERIODS + 1;
    localparam int SETTLE_PERIODS = 68;
    localparam int OVERHEAD_NS = 400;
    localparam int OVERHEAD_CYCLES = (OVERHEAD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int BUFFER_EXTRA_CLKS = 8;

    // 65536 / 69 rounded, so the 69-tap sum lands at unity gain
    localparam int GAIN_RECIP = 950;
    localparam int LL_GAIN_SHIFT = 16;
    localparam int OUT_SHIFT_BASE = 5;
    localparam logic [12:0] RATIO_BASE = 13'h0020;
    localparam logic signed [PROD_W-1:0] CLAMP_HI = 36'sh0_0000_7FFF;
    localparam logic signed [PROD_W-1:0] CLAMP_LO = 36'shF_FFFF_8000;
    localparam logic [WORD_W-1:0] FULL_POS = 16'h7FFF;
    localparam logic [WORD_W-1:0] FULL_NEG = 16'h8000;

    localparam int REG_ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INT_CLEAR = 8'h08;
    localparam logic [7:0] ADDR_INT_EN = 8'h0C;
    localparam logic [7:0] ADDR_DATA = 8'h10;

    localparam int CTRL_RATIO_LSB = 0;
    localparam int CTRL_MODE_BIT = 3;
    localparam int CTRL_SPEED_BIT = 4;
    localparam int CTRL_BUF_BIT = 5;
    localparam int CTRL_SYNC_BIT = 8;
    localparam int DATA_SAT_BIT = 16;
    localparam int DATA_SETTLED_BIT = 17;

    localparam int EV_W = 3;
    localparam int EV_READY = 0;
    localparam int EV_SAT = 1;
    localparam int EV_RESTART = 2;

    localparam logic [2:0] RATIO_CODE_RESET = 3'h0;
    localparam logic [EV_W-1:0] INT_EN_RESET = 3'h0;

    typedef enum logic {
        MODE_WIDEBAND = 1'b0,
        MODE_LOW_LATENCY = 1'b1
    } filter_mode_t;

    typedef enum logic {
        SPEED_HIGH = 1'b0,
        SPEED_LOW = 1'b1
    } speed_mode_t;

    typedef struct packed {
        logic [2:0] ratio_code;
        filter_mode_t mode;
        speed_mode_t speed;
        logic buf_en;
    } ctrl_t;

    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic sat;
    } result_t;

    // last sample index of a conversion for a ratio code
    function automatic logic [11:0] decimation_last(input logic [2:0] code);
        logic [12:0] r;
        r = RATIO_BASE << code;
        return 12'(r - 13'h0001);
    endfunction

    // shift down to 16 bits and clamp at the full-scale codes
    function automatic logic [WORD_W-1:0] scale_word(input logic signed [PROD_W-1:0] v,
                                                     input logic [4:0] sh);
        logic signed [PROD_W-1:0] q;
        q = v >>> sh;
        if (q > CLAMP_HI) begin
            return FULL_POS;
        end else if (q < CLAMP_LO) begin
            return FULL_NEG;
        end
        return q[WORD_W-1:0];
    endfunction

endpackage

//--- tb/wideband_filter_props.sv
// port-level checks for the decimating filter
`timescale 1ns/1ns
`default_nettype none
module wideband_filter_props
    import wideband_filter_pkg::*;
#(
    parameter int unsigned CONV_CLK_DIV = 1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic modulator_saturated,
    input wire logic sync_n,
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [WORD_W-1:0] data_word,
    input wire logic modulator_saturation_flag,
    input wire logic conversion_ready_strobe_n,
    input wire logic irq
);
    localparam int WB_MIN = 67 * 64;
    localparam int WB_MAX = 68 * 64 + 20;
    localparam int LL_MAX = 64 + 20;
    logic [15:0] gap_reg, quiet_reg, hi_reg, lo_reg;
    logic pend_reg, ll_reg, slow_reg, fast0_reg, sync_d_reg;
    logic restart, pub;
    // counters stop at bit 15 so the sums below never wrap
    function automatic logic [15:0] inc(input logic [15:0] x);
        return x + 16'(!x[15]);
    endfunction
    assign pub = !conversion_ready_strobe_n;
    assign restart = (sync_d_reg & ~sync_n)
        | (reg_wr & (reg_addr == ADDR_CTRL) & reg_wdata[CTRL_SYNC_BIT]);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gap_reg <= '0;
            quiet_reg <= '0;
            hi_reg <= '0;
            lo_reg <= '0;
            pend_reg <= 1'b1;
            ll_reg <= 1'b0;
            slow_reg <= 1'b0;
            fast0_reg <= 1'b1;
            sync_d_reg <= 1'b1;
        end else begin
            sync_d_reg <= sync_n;
            gap_reg <= pub ? 16'h0001 : inc(gap_reg);
            quiet_reg <= restart ? 16'h0000 : inc(quiet_reg);
            pend_reg <= restart | (pend_reg & ~pub);
            hi_reg <= modulator_saturated ? inc(hi_reg) : 16'h0000;
            lo_reg <= modulator_saturated ? 16'h0000 : inc(lo_reg);
            if (reg_wr && reg_addr == ADDR_CTRL) begin
                ll_reg <= reg_wdata[CTRL_MODE_BIT];
                slow_reg <= reg_wdata[CTRL_SPEED_BIT];
                fast0_reg <= (reg_wdata[5:0] & 6'h37) == 6'h00;
            end
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    strobe_pulse_a: assert property (pub |=> !pub)
        else $error("strobe longer than one cycle");
    word_hold_a: assert property (!pub |->
        $stable(data_word) && $stable(modulator_saturation_flag))
        else $error("word changed without strobe");
    fast_gap_a: assert property (pub && !slow_reg |-> gap_reg >= 16'(64 * CONV_CLK_DIV))
        else $error("words closer than one conversion");
    slow_gap_a: assert property (pub && slow_reg |-> gap_reg >= 16'(512 * CONV_CLK_DIV))
        else $error("low speed words too close");
    wb_quiet_a: assert property (pub && pend_reg && !ll_reg |->
        quiet_reg >= 16'(WB_MIN * CONV_CLK_DIV))
        else $error("unsettled word published");
    wb_latency_a: assert property (pend_reg && !ll_reg && fast0_reg |->
        quiet_reg <= 16'(WB_MAX))
        else $error("first wideband word late");
    ll_latency_a: assert property (pend_reg && ll_reg && fast0_reg |->
        quiet_reg <= 16'(LL_MAX))
        else $error("low latency word late");
    sat_set_a: assert property (pub && hi_reg > gap_reg + 16'd10 |->
        modulator_saturation_flag)
        else $error("saturation not latched");
    sat_clear_a: assert property (pub && lo_reg > gap_reg + 16'd10 |->
        !modulator_saturation_flag)
        else $error("saturation not refreshed");
    cover property (pub && modulator_saturation_flag);
    cover property (pub && pend_reg && ll_reg);
    cover property (irq);
endmodule
`default_nettype wire

//--- tb/modulator_model.sv
// behavioural modulator supplying quantizer words and saturation
`timescale 1ns/1ns
`default_nettype none
module modulator_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic signed [4:0] level,
    input wire logic sat_cmd,
    output logic [4:0] modulator_word,
    output logic modulator_saturated
);
    logic toggle_reg;
    logic dither;
    // mid levels wobble one code per clock like a real loop; extremes would wrap
    assign dither = (level >= 5'sh02 && level <= 5'sh0E) || (level <= 5'sh1E && level >= 5'sh12);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            toggle_reg <= 1'b0;
            modulator_word <= 5'h0A;
            modulator_saturated <= 1'b0;
        end else begin
            toggle_reg <= ~toggle_reg;
            modulator_word <= dither ? (toggle_reg ? level + 5'sh01 : level - 5'sh01) : level;
            modulator_saturated <= sat_cmd;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_wideband_decimation_filter.sv
// self-checking bench for the decimating wideband filter
`timescale 1ns/1ns
`default_nettype none
module tb_wideband_decimation_filter;
    import wideband_filter_pkg::*;
    logic mclk, resetn, sync_n, reg_wr, reg_rd, sat_cmd;
    logic modulator_saturated, modulator_saturation_flag, conversion_ready_strobe_n, irq;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [4:0] modulator_word;
    logic signed [4:0] level;
    logic [15:0] data_word, lfsr;
    logic [7:0] addrs [5] = '{ADDR_CTRL, ADDR_STATUS, ADDR_INT_CLEAR, ADDR_INT_EN, 8'h14};
    int err_total, check_count, n, n0;
    wideband_decimation_filter #(.CONV_CLK_DIV(1)) i_dut (.mclk(mclk), .resetn(resetn),
        .modulator_word(modulator_word), .modulator_saturated(modulator_saturated),
        .sync_n(sync_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_word(data_word),
        .modulator_saturation_flag(modulator_saturation_flag),
        .conversion_ready_strobe_n(conversion_ready_strobe_n), .irq(irq));
    modulator_model i_mod (.mclk(mclk), .resetn(resetn), .level(level), .sat_cmd(sat_cmd),
        .modulator_word(modulator_word), .modulator_saturated(modulator_saturated));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic end_sim();
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cmp_cnt(input string what, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        rd = reg_rdata;
    endtask
    // counts clocks until the next strobe; a hang ends the run
    task automatic wait_strobe(input int lim);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
            if (n > lim) begin
                err_total++;
                $display("[FAIL] strobe expected within %0d seen none", lim);
                end_sim();
            end
        end while (conversion_ready_strobe_n !== 1'b0);
    endtask
    function automatic logic [15:0] exp_word(input logic signed [4:0] v);
        return v > 0 ? FULL_POS : (v < 0 ? FULL_NEG : 16'h0000);
    endfunction
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    initial begin
        resetn = 1'b0;
        sync_n = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        sat_cmd = 1'b0;
        level = 5'sh0F;
        lfsr = 16'h5102;
        err_total = 0;
        check_count = 0;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        foreach (addrs[i]) begin
            reg_read(addrs[i]);
            cmp_val("reset read", 32'h0, rd);
        end
        cmp_val("strobe idle", 32'h1, {31'h0, conversion_ready_strobe_n});
        wait_strobe(4500);
        cmp_cnt("first word", 67 * 64, 68 * 64 + 12, n);
        cmp_val("clamp high", {16'h0, FULL_POS}, {16'h0, data_word});
        wait_strobe(100);
        cmp_cnt("spacing", 64, 64, n);
        for (int s = 0; s < 3; s++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge mclk);
            level <= lfsr[15] ? 5'sh1E - 5'(lfsr[3:0] % 13) : 5'sh02 + 5'(lfsr[3:0] % 13);
            wait_strobe(100);
            cmp_cnt("no suppression", 63, 64, n);
            repeat (70) wait_strobe(100);
            cmp_val("settled", {16'h0, exp_word(level)}, {16'h0, data_word});
        end
        @(posedge mclk);
        sat_cmd <= 1'b1;
        wait_strobe(100);
        cmp_val("sat flag", 32'h1, {31'h0, modulator_saturation_flag});
        wait_strobe(100);
        @(posedge mclk);
        sat_cmd <= 1'b0;
        wait_strobe(100);
        reg_read(ADDR_DATA);
        cmp_val("data reg", {14'h0, 2'h3, exp_word(level)}, rd);
        wait_strobe(100);
        cmp_val("sat refresh", 32'h0, {31'h0, modulator_saturation_flag});
        reg_write(ADDR_INT_EN, 32'h1);
        repeat (3) @(negedge mclk);
        cmp_val("irq on", 32'h1, {31'h0, irq});
        reg_write(ADDR_INT_CLEAR, 32'h7);
        repeat (3) @(negedge mclk);
        cmp_val("irq clear", 32'h0, {31'h0, irq});
        reg_read(ADDR_STATUS);
        cmp_val("status clear", 32'h0, rd & 32'h3);
        wait_strobe(100);
        repeat (2) @(negedge mclk);
        cmp_val("irq again", 32'h1, {31'h0, irq});
        reg_write(ADDR_INT_EN, 32'h0);
        repeat (3) @(negedge mclk);
        cmp_val("irq masked", 32'h0, {31'h0, irq});
        @(posedge mclk);
        level <= 5'sh00;
        sync_n <= 1'b0;
        repeat (4) @(posedge mclk);
        sync_n <= 1'b1;
        wait_strobe(4500);
        cmp_cnt("sync latency", 68 * 64, 68 * 64 + 10, n);
        cmp_val("history clear", 32'h0, {16'h0, data_word});
        reg_read(ADDR_STATUS);
        cmp_val("restart bit", 32'h4, rd & 32'h4);
        reg_write(ADDR_CTRL, 32'h101);
        wait_strobe(9000);
        cmp_cnt("ratio 64 latency", 68 * 128, 68 * 128 + 12, n);
        wait_strobe(300);
        cmp_cnt("ratio 64 spacing", 128, 128, n);
        @(posedge mclk);
        level <= 5'sh10;
        for (int c = 0; c < 8; c++) begin
            reg_write(ADDR_CTRL, 32'h108 | c);
            wait_strobe(200 << c);
            n0 = (c == 0) ? n : n0;
            wait_strobe(200 << c);
            cmp_cnt("ratio spacing", 64 << c, 64 << c, n);
        end
        cmp_val("clamp low", {16'h0, FULL_NEG}, {16'h0, data_word});
        reg_write(ADDR_CTRL, 32'h128);
        wait_strobe(200);
        cmp_cnt("buffer delay", n0 + 8, n0 + 8, n);
        reg_write(ADDR_CTRL, 32'h118);
        wait_strobe(2000);
        wait_strobe(2000);
        cmp_cnt("low speed", 512, 512, n);
        end_sim();
    end
endmodule
bind wideband_decimation_filter wideband_filter_props #(.CONV_CLK_DIV(CONV_CLK_DIV)) i_props (
    .mclk(mclk), .resetn(resetn), .modulator_saturated(modulator_saturated), .sync_n(sync_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .data_word(data_word),
    .modulator_saturation_flag(modulator_saturation_flag),
    .conversion_ready_strobe_n(conversion_ready_strobe_n), .irq(irq));
`default_nettype wire
